// >>> inc/ccu_pkg.sv
/*
 capture/compare unit package: register offsets, field positions, mode codes, reset values.
 assumes a 32-bit axi4-lite slave with one aligned word per register.
*/
package ccu_pkg;
   // ------------------------------------------------------------
   // register indices (printed offsets), byte address = 4 * index
   // ------------------------------------------------------------
   localparam logic [7:0] CCU_IDX_IRQ_FLAGS = 8'h0c; // peripheral_irq_flags
   localparam logic [7:0] CCU_IDX_CONTROL = 8'h17; // capture_compare_control
   localparam logic [7:0] CCU_IDX_IRQ_ENABLES = 8'h8c; // peripheral_irq_enables
   localparam logic [7:0] CCU_IDX_MATCH_LOW = 8'h15; // match_value_low
   localparam logic [7:0] CCU_IDX_MATCH_HIGH = 8'h16; // match_value_high
   localparam logic [7:0] CCU_IDX_TIMER_LOW = 8'h0e; // sixteen_bit_timer low
   localparam logic [7:0] CCU_IDX_TIMER_HIGH = 8'h0f; // sixteen_bit_timer high
   localparam logic [7:0] CCU_IDX_PORT_OUT = 8'h40; // pin port data latch
   localparam logic [7:0] CCU_IDX_PORT_DIR = 8'h41; // port_b_direction (bit 3)
   localparam int CCU_ADDR_W = 12;
   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int CCU_FLAG_BIT = 2; // unit_event_flag / unit_event_enable
   localparam int CCU_DIR_BIT = 3; // pin direction bit
   localparam logic [7:0] CCU_FLAGS_RST = 8'h00;
   localparam logic [7:0] CCU_CTRL_RST = 8'h00;
   localparam logic [7:0] CCU_DIR_RST = 8'hff;
   localparam logic [5:0] CCU_CTRL_MASK = 6'h3f; // bits 7:6 read as zero
   localparam logic [7:0] CCU_FLAGS_MASK = 8'hf7; // bit 3 unimplemented
   // ------------------------------------------------------------
   // mode codes
   // ------------------------------------------------------------
   localparam logic [3:0] CCU_MODE_OFF = 4'h0;
   localparam logic [3:0] CCU_MODE_CAP_FALL = 4'h4;
   localparam logic [3:0] CCU_MODE_CAP_RISE = 4'h5;
   localparam logic [3:0] CCU_MODE_CAP_RISE4 = 4'h6;
   localparam logic [3:0] CCU_MODE_CAP_RISE16 = 4'h7;
   localparam logic [3:0] CCU_MODE_CMP_SET = 4'h8;
   localparam logic [3:0] CCU_MODE_CMP_CLR = 4'h9;
   localparam logic [3:0] CCU_MODE_CMP_SOFT = 4'ha;
   localparam logic [3:0] CCU_MODE_CMP_TRIG = 4'hb;
   localparam logic [1:0] CCU_MODE_PWM_TOP = 2'h3; // 11xx
   localparam logic [3:0] CCU_PS4_LAST = 4'h3; // 4th rising edge
   localparam logic [3:0] CCU_PS16_LAST = 4'hf; // 16th rising edge
   localparam logic [1:0] CCU_RESP_OKAY = 2'h0;
   localparam logic [1:0] CCU_RESP_SLVERR = 2'h2;
endpackage

// >>> inc/ccu_evt_if.sv
/*
 capture_compare_unit internal interface: pin sample toward the edge detector, events back.
 assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
interface ccu_evt_if;
   logic pin_level; // pin level as seen by the unit
   logic rise; // one-cycle rising edge pulse
   logic fall; // one-cycle falling edge pulse
   modport det (input pin_level, output rise, output fall);
   modport core (output pin_level, input rise, input fall);
endinterface

// >>> hw/ccu_edge_det.sv
/*
 capture_compare_unit edge detector: synchroniser and edge pulses.
 assumes pin_level is an ordinary level in the core_clk domain or asynchronous.
*/
`timescale 1ns/1ps
module ccu_edge_det (
   input wire logic core_clk,
   input wire logic sys_rst,
   ccu_evt_if.det evt
);
   logic sync1_r, sync1_nxt; // first stage, read only by second stage
   logic sync2_r, sync2_nxt; // second stage
   logic prev_r, prev_nxt; // delayed copy for edge compare
   // ----------------------------------------
   // next values
   // ----------------------------------------
   always_comb begin
      sync1_nxt = evt.pin_level;
      sync2_nxt = sync1_r;
      prev_nxt = sync2_r;
   end
   // registers
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         prev_r <= 1'b0;
      end else begin
         sync1_r <= sync1_nxt;
         sync2_r <= sync2_nxt;
         prev_r <= prev_nxt;
      end
   end
   // edges from the synchronised level only [RULE22]
   assign evt.rise = sync2_r & ~prev_r;
   assign evt.fall = ~sync2_r & prev_r;
   a_rise_follows_pin: assert property (@(posedge core_clk) disable iff (sys_rst)
      evt.rise |-> $past(evt.pin_level, 3) == 1'b0 && $past(evt.pin_level, 2)) // [RULE22]
      else $error("rise pulse without synchronised low-high step");
endmodule

// >>> hw/ccu_top.sv
/*
 capture_compare_unit top: axi4-lite registers, 16-bit timer, capture, compare, pwm latch.
 assumes core_clk at 100 MHz, synchronous active-high sys_rst, pin buffer outside.
*/
`timescale 1ns/1ps
// Functional notes
// RULE1 - match value held as two byte registers
// RULE2 - mode 0000 turns unit off, resets state
// RULE3 - modes 0100-0111 capture fall, rise, 4th, 16th
// RULE4 - mode 1000 drives pin high on match
// RULE5 - mode 1001 drives pin low on match
// RULE6 - mode 1010 flag only, pin untouched
// RULE7 - mode 1011 flag plus special event pulse
// RULE8 - modes 11xx pwm, duty in low byte
// RULE9 - capture copies whole timer into holding pair
// RULE10 - capture sets flag bit 2, sticky
// RULE11 - new capture overwrites unread value
// RULE12 - port write on output pin can capture
// RULE13 - software keeps timer synchronous
// RULE14 - prescaler cleared when off or not capturing
// RULE15 - prescale change keeps count, may flag
// RULE16 - software masks enable during mode change
// RULE17 - software clears control before new prescale
// RULE18 - compare on every timer update, act together
// RULE19 - writing control zero forces compare latch low
// RULE20 - special event resets both timer bytes
// RULE21 - software sets direction bit for use
// RULE22 - pin synchronised, edges before prescaler
module ccu_top
   import ccu_pkg::*;
#(
   parameter int TIMER_W = 16
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [ccu_pkg::CCU_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ccu_pkg::CCU_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic event_pin_in,
   output logic event_pin_out,
   output logic event_pin_oe,
   input wire logic timer_tick,
   output logic special_event,
   output logic unit_irq
);
   import ccu_pkg::*;

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0] flags_r, flags_nxt; // peripheral_irq_flags
   logic [7:0] enables_r, enables_nxt; // peripheral_irq_enables
   logic [5:0] ctrl_r, ctrl_nxt; // capture_compare_control low six bits
   logic [7:0] match_low_r, match_low_nxt; // match_value_low
   logic [7:0] match_high_r, match_high_nxt; // match_value_high
   logic [TIMER_W-1:0] timer_r, timer_nxt; // sixteen_bit_timer
   logic [3:0] pscnt_r, pscnt_nxt; // capture prescaler count
   logic cmp_latch_r, cmp_latch_nxt; // compare output latch
   logic port_out_r, port_out_nxt; // general port data latch
   logic [7:0] dir_r, dir_nxt; // port_b_direction
   logic sev_r, sev_nxt; // special event pulse
   logic irq_r, irq_nxt; // flag and enable
   logic pin_out_r, pin_out_nxt; // driven pin level
   logic pin_oe_r, pin_oe_nxt; // pin drive enable
   // bus state
   logic aw_hold_r, aw_hold_nxt; // write address taken
   logic w_hold_r, w_hold_nxt; // write data taken
   logic [7:0] aw_idx_r, aw_idx_nxt; // latched write index
   logic [31:0] wdata_r, wdata_nxt; // latched write data
   logic wstrb0_r, wstrb0_nxt; // latched lane 0 strobe
   logic awr_r, awr_nxt, wr_r, wr_nxt; // channel readies
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic arr_r, arr_nxt, rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;

   ccu_evt_if evt ();
   // ----------------------------------------
   // decoded mode
   // ----------------------------------------
   logic [3:0] mode;
   logic is_cap, is_cmp, is_pwm, wr_go, rd_go, cap_hit, cmp_hit, port_lvl;
   logic [7:0] wr_byte;
   assign mode = ctrl_r[3:0];
   assign is_cap = mode[3:2] == 2'h1; // [RULE3]
   assign is_cmp = mode[3:2] == 2'h2;
   assign is_pwm = mode[3:2] == CCU_MODE_PWM_TOP; // [RULE8]
   assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
   assign rd_go = s_axi_arvalid && arr_r;
   assign wr_byte = wdata_r[7:0];

   // output pin on direction clear: port latch or unit latch drives the pin
   // so a port write can make an edge the capture sees [RULE12]
   assign port_lvl = dir_r[CCU_DIR_BIT] ? event_pin_in : pin_out_r;
   assign evt.pin_level = port_lvl;

   ccu_edge_det u_edge (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .evt(evt)
   );

   // ----------------------------------------
   // capture event with prescaler
   // ----------------------------------------
   always_comb begin
      pscnt_nxt = pscnt_r;
      cap_hit = 1'b0;
      if (!is_cap) begin
         pscnt_nxt = 4'h0; // [RULE14] also off mode [RULE2]
      end else begin
         unique case (mode)
            CCU_MODE_CAP_FALL: cap_hit = evt.fall; // [RULE3]
            CCU_MODE_CAP_RISE: cap_hit = evt.rise;
            CCU_MODE_CAP_RISE4: begin
               // count kept across prescale changes [RULE15]
               if (evt.rise) begin
                  cap_hit = pscnt_r[1:0] == CCU_PS4_LAST[1:0];
                  pscnt_nxt = pscnt_r + 4'h1;
               end
            end
            default: begin
               if (evt.rise) begin
                  cap_hit = pscnt_r == CCU_PS16_LAST;
                  pscnt_nxt = pscnt_r + 4'h1;
               end
            end
         endcase
      end
   end

   // compare evaluated on each timer update [RULE18]
   assign cmp_hit = is_cmp && timer_tick && ({match_high_r, match_low_r} == timer_r);

   // ----------------------------------------
   // unit datapath next values
   // ----------------------------------------
   always_comb begin
      timer_nxt = timer_tick ? timer_r + 16'h0001 : timer_r;
      match_low_nxt = match_low_r;
      match_high_nxt = match_high_r;
      flags_nxt = flags_r;
      enables_nxt = enables_r;
      ctrl_nxt = ctrl_r;
      cmp_latch_nxt = cmp_latch_r;
      port_out_nxt = port_out_r;
      dir_nxt = dir_r;
      sev_nxt = 1'b0;
      // software writes, lane 0 only carries byte registers
      if (wr_go && wstrb0_r) begin
         unique case (aw_idx_r)
            CCU_IDX_IRQ_FLAGS: flags_nxt = wr_byte & CCU_FLAGS_MASK;
            CCU_IDX_IRQ_ENABLES: enables_nxt = wr_byte & CCU_FLAGS_MASK;
            CCU_IDX_CONTROL: begin
               ctrl_nxt = wr_byte[5:0] & CCU_CTRL_MASK;
               if (wr_byte[5:0] == 6'h00) begin
                  cmp_latch_nxt = 1'b0; // [RULE19] [RULE2]
               end
            end
            CCU_IDX_MATCH_LOW: match_low_nxt = wr_byte; // [RULE1]
            CCU_IDX_MATCH_HIGH: begin
               if (!is_pwm) begin
                  match_high_nxt = wr_byte; // [RULE1] read-only in pwm
               end
            end
            CCU_IDX_TIMER_LOW: timer_nxt = {timer_r[15:8], wr_byte};
            CCU_IDX_TIMER_HIGH: timer_nxt = {wr_byte, timer_r[7:0]};
            CCU_IDX_PORT_OUT: port_out_nxt = wr_byte[CCU_DIR_BIT];
            CCU_IDX_PORT_DIR: dir_nxt = wr_byte;
            default: ;
         endcase
      end
      // capture overwrites any unread value [RULE9] [RULE11]
      if (cap_hit) begin
         {match_high_nxt, match_low_nxt} = timer_r;
      end
      // compare actions and flag in the same cycle [RULE18]
      if (cmp_hit) begin
         unique case (mode)
            CCU_MODE_CMP_SET: cmp_latch_nxt = 1'b1; // [RULE4]
            CCU_MODE_CMP_CLR: cmp_latch_nxt = 1'b0; // [RULE5]
            CCU_MODE_CMP_SOFT: ; // pin untouched [RULE6]
            default: begin
               sev_nxt = 1'b1; // [RULE7]
               timer_nxt = '0; // both bytes reset [RULE20]
            end
         endcase
      end
      // pwm duty: low byte upper bits, ctrl 5:4 low bits, latched high [RULE8]
      if (is_pwm) begin
         cmp_latch_nxt = timer_r[9:0] < {match_low_r, ctrl_r[5:4]};
         if (timer_tick && timer_r[9:0] == 10'h000) begin
            match_high_nxt = match_low_r;
         end
      end
      // a control clear beats match and pwm updates of the latch [RULE19]
      if (wr_go && wstrb0_r && aw_idx_r == CCU_IDX_CONTROL && wr_byte[5:0] == 6'h00) begin
         cmp_latch_nxt = 1'b0;
      end
      // set wins over a software clear [RULE10]
      if (cap_hit || cmp_hit) begin
         flags_nxt[CCU_FLAG_BIT] = 1'b1;
      end
   end

   // pin drive: unit latch in compare and pwm modes (control bit 3 set), else port latch
   always_comb begin
      pin_oe_nxt = !dir_nxt[CCU_DIR_BIT];
      pin_out_nxt = (ctrl_nxt[3] ? cmp_latch_nxt : port_out_nxt);
      irq_nxt = flags_nxt[CCU_FLAG_BIT] & enables_nxt[CCU_FLAG_BIT];
   end

   // registers of the unit
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         timer_r <= '0;
         match_low_r <= 8'h00;
         match_high_r <= 8'h00;
         flags_r <= CCU_FLAGS_RST;
         enables_r <= CCU_FLAGS_RST;
         ctrl_r <= CCU_CTRL_RST[5:0];
         cmp_latch_r <= 1'b0;
         port_out_r <= 1'b0;
         dir_r <= CCU_DIR_RST;
         pscnt_r <= 4'h0; // [RULE14]
         sev_r <= 1'b0;
         irq_r <= 1'b0;
         pin_out_r <= 1'b0;
         pin_oe_r <= 1'b0;
      end else begin
         timer_r <= timer_nxt;
         match_low_r <= match_low_nxt;
         match_high_r <= match_high_nxt;
         flags_r <= flags_nxt;
         enables_r <= enables_nxt;
         ctrl_r <= ctrl_nxt;
         cmp_latch_r <= cmp_latch_nxt;
         port_out_r <= port_out_nxt;
         dir_r <= dir_nxt;
         pscnt_r <= pscnt_nxt;
         sev_r <= sev_nxt;
         irq_r <= irq_nxt;
         pin_out_r <= pin_out_nxt;
         pin_oe_r <= pin_oe_nxt;
      end
   end

   // ----------------------------------------
   // axi4-lite slave
   // ----------------------------------------
   always_comb begin
      aw_hold_nxt = aw_hold_r;
      w_hold_nxt = w_hold_r;
      aw_idx_nxt = aw_idx_r;
      wdata_nxt = wdata_r;
      wstrb0_nxt = wstrb0_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      // address and data taken in either order
      if (s_axi_awvalid && awr_r) begin
         aw_hold_nxt = 1'b1;
         aw_idx_nxt = s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && wr_r) begin
         w_hold_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb0_nxt = s_axi_wstrb[0];
      end
      if (wr_go) begin
         aw_hold_nxt = 1'b0;
         w_hold_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         unique case (aw_idx_r)
            CCU_IDX_IRQ_FLAGS, CCU_IDX_IRQ_ENABLES, CCU_IDX_CONTROL, CCU_IDX_MATCH_LOW,
            CCU_IDX_MATCH_HIGH, CCU_IDX_TIMER_LOW, CCU_IDX_TIMER_HIGH, CCU_IDX_PORT_OUT,
            CCU_IDX_PORT_DIR: bresp_nxt = CCU_RESP_OKAY;
            default: bresp_nxt = CCU_RESP_SLVERR;
         endcase
      end
      if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      awr_nxt = !aw_hold_nxt && !bvalid_nxt;
      wr_nxt = !w_hold_nxt && !bvalid_nxt;
   end

   // read side: one read under way
   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (rd_go) begin
         rvalid_nxt = 1'b1;
         rresp_nxt = CCU_RESP_OKAY;
         unique case (s_axi_araddr[9:2])
            CCU_IDX_IRQ_FLAGS: rdata_nxt = {24'h0, flags_r};
            CCU_IDX_IRQ_ENABLES: rdata_nxt = {24'h0, enables_r};
            CCU_IDX_CONTROL: rdata_nxt = {26'h0, ctrl_r};
            CCU_IDX_MATCH_LOW: rdata_nxt = {24'h0, match_low_r};
            CCU_IDX_MATCH_HIGH: rdata_nxt = {24'h0, match_high_r};
            CCU_IDX_TIMER_LOW: rdata_nxt = {24'h0, timer_r[7:0]};
            CCU_IDX_TIMER_HIGH: rdata_nxt = {24'h0, timer_r[15:8]};
            CCU_IDX_PORT_OUT: rdata_nxt = {28'h0, port_lvl, 3'h0};
            CCU_IDX_PORT_DIR: rdata_nxt = {24'h0, dir_r};
            default: begin
               rdata_nxt = 32'h0;
               rresp_nxt = CCU_RESP_SLVERR;
            end
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
      arr_nxt = !rvalid_nxt && !rd_go;
   end

   // bus registers
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         aw_idx_r <= 8'h00;
         wdata_r <= 32'h0;
         wstrb0_r <= 1'b0;
         awr_r <= 1'b0;
         wr_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= CCU_RESP_OKAY;
         arr_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0;
         rresp_r <= CCU_RESP_OKAY;
      end else begin
         aw_hold_r <= aw_hold_nxt;
         w_hold_r <= w_hold_nxt;
         aw_idx_r <= aw_idx_nxt;
         wdata_r <= wdata_nxt;
         wstrb0_r <= wstrb0_nxt;
         awr_r <= awr_nxt;
         wr_r <= wr_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         arr_r <= arr_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   assign s_axi_awready = awr_r;
   assign s_axi_wready = wr_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arr_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign event_pin_out = pin_out_r;
   assign event_pin_oe = pin_oe_r;
   assign special_event = sev_r;
   assign unit_irq = irq_r;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   a_capture_copies_timer: assert property (cap_hit |=> // [RULE9]
      {match_high_r, match_low_r} == $past(timer_r)) else $error("capture lost timer");
   a_capture_sets_flag: assert property (cap_hit |=> flags_r[CCU_FLAG_BIT]) // [RULE10]
      else $error("capture flag not set");
   a_compare_sets_flag: assert property (cmp_hit |=> flags_r[CCU_FLAG_BIT]) // [RULE18]
      else $error("compare flag not set");
   a_cmp_high_latch: assert property (cmp_hit && mode == CCU_MODE_CMP_SET |=> // [RULE4]
      cmp_latch_r) else $error("set-on-match failed");
   a_cmp_low_latch: assert property (cmp_hit && mode == CCU_MODE_CMP_CLR |=> // [RULE5]
      !cmp_latch_r) else $error("clear-on-match failed");
   a_soft_keeps_pin: assert property (cmp_hit && mode == CCU_MODE_CMP_SOFT |=> // [RULE6]
      cmp_latch_r == $past(cmp_latch_r)) else $error("soft mode moved latch");
   a_trig_resets_timer: assert property (cmp_hit && mode == CCU_MODE_CMP_TRIG |=> // [RULE20]
      special_event && timer_r == '0) else $error("special event missing");
   a_prescale_cleared: assert property (!is_cap |=> pscnt_r == 4'h0) // [RULE14]
      else $error("prescaler not cleared");
   sequence s_ctrl_zero;
      wr_go && wstrb0_r && aw_idx_r == CCU_IDX_CONTROL && wr_byte[5:0] == 6'h00;
   endsequence
   a_zero_ctrl_low: assert property (s_ctrl_zero |=> // [RULE19]
      !cmp_latch_r && mode == CCU_MODE_OFF) else $error("control clear left latch high");
endmodule

// >>> test/ccu_pin_model.sv
/*
 partner model: external signal source or load on the unit's event pin.
 assumes the unit drives the pin only while its output enable is high.
*/
`timescale 1ns/1ps
module ccu_pin_model (
   input wire logic drive_level,
   input wire logic pin_out,
   input wire logic pin_oe,
   output logic pin_in
);
   // wire level: unit wins while enabled, else the outside source
   assign pin_in = pin_oe ? pin_out : drive_level;
endmodule

// >>> test/ccu_top_tb_top.sv
/*
 self-checking bench for the capture/compare unit: axi4-lite tasks, pin source.
 assumes ccu_pkg indices and the handshake timing of the unit's slave port.
*/
`timescale 1ns/1ps
module ccu_top_tb_top;
   import ccu_pkg::*;
   // ---------------------------
   // short register aliases
   // ---------------------------
   localparam logic [7:0] FLG = CCU_IDX_IRQ_FLAGS, CTL = CCU_IDX_CONTROL;
   localparam logic [7:0] ML = CCU_IDX_MATCH_LOW, MH = CCU_IDX_MATCH_HIGH;
   localparam logic [7:0] TL = CCU_IDX_TIMER_LOW, TH = CCU_IDX_TIMER_HIGH;
   logic core_clk = 0, sys_rst = 1, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic [11:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rq, rdat;
   logic [1:0] rs, bresp, rresp;
   logic awr, wr_rdy, bv, arr, rv, pin_in, pin_out, pin_oe, tick = 0, src = 0, sev, irq;
   int n_errors = 0, n_compared = 0, se_cnt = 0;
   always #5 core_clk = ~core_clk;
   // count special event pulses
   always @(posedge core_clk) if (sev) se_cnt++;
   ccu_top ccu_top_inst (.core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(awa),
      .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv),
      .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
      .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr),
      .event_pin_in(pin_in), .event_pin_out(pin_out), .event_pin_oe(pin_oe),
      .timer_tick(tick), .special_event(sev), .unit_irq(irq));
   ccu_pin_model ccu_pin_model_inst (.drive_level(src), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_in(pin_in));
   // ---------------------------
   // bus and compare tasks
   // ---------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // write one byte register, address and data offered together
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      bit ad, dd;
      @(posedge core_clk);
      awa <= {2'h0, idx, 2'h0};
      wd <= {24'h0, d};
      awv <= 1;
      wv <= 1;
      br <= 1;
      ad = 0;
      dd = 0;
      while (!(ad && dd)) begin
         @(posedge core_clk);
         if (!ad && awr) begin
            ad = 1;
            awv <= 0;
         end
         if (!dd && wr_rdy) begin
            dd = 1;
            wv <= 0;
         end
      end
      while (!bv) @(posedge core_clk);
      br <= 0;
   endtask
   // read one register into rq and rs
   task automatic rd(input logic [7:0] idx);
      @(posedge core_clk);
      ara <= {2'h0, idx, 2'h0};
      arv <= 1;
      rr <= 1;
      do @(posedge core_clk); while (!arr);
      arv <= 0;
      while (!rv) @(posedge core_clk);
      rq = rdat;
      rs = rresp;
      rr <= 0;
   endtask
   task automatic rc(input logic [7:0] idx, input logic [7:0] e);
      rd(idx);
      chk(rq, {24'h0, e});
   endtask
   // one high pulse on the pin, long enough for the synchroniser
   task automatic pulse();
      @(posedge core_clk) src <= 1;
      repeat (6) @(posedge core_clk);
      src <= 0;
      repeat (6) @(posedge core_clk);
   endtask
   // capture: n pulses, flag only on the last, timer copied whole
   task automatic cap(input logic [7:0] m, input int n, input logic [15:0] tv);
      wr(CTL, 8'h00);
      wr(FLG, 8'h00);
      wr(TL, tv[7:0]);
      wr(TH, tv[15:8]);
      wr(CTL, m);
      repeat (n - 1) pulse();
      rc(FLG, 8'h00);
      pulse();
      rc(FLG, 8'h04);
      rc(ML, tv[7:0]);
      rc(MH, tv[15:8]);
      chk(irq, 1);
   endtask
   // compare: timer runs from 0 past match 0x0020
   task automatic cmp(input logic [7:0] m, input bit clr);
      if (clr) wr(CTL, 8'h00);
      wr(FLG, 8'h00);
      wr(TL, 8'h00);
      wr(TH, 8'h00);
      wr(ML, 8'h20);
      wr(MH, 8'h00);
      wr(CTL, m);
      se_cnt = 0;
      @(posedge core_clk) tick <= 1;
      repeat (48) @(posedge core_clk);
      tick <= 0;
      rc(FLG, 8'h04);
   endtask
   task automatic finish_test();
      $display("n_errors=%0d n_compared=%0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ---------------------------
   // main sequence and watchdog
   // ---------------------------
   initial begin
      #400us;
      n_errors++;
      finish_test();
   end
   initial begin
      repeat (16) @(posedge core_clk);
      sys_rst <= 0;
      rc(FLG, 8'h00);
      rc(CTL, 8'h00);
      rc(CCU_IDX_IRQ_ENABLES, 8'h00);
      rd(8'h33);
      chk(rs, CCU_RESP_SLVERR);
      wr(ML, 8'ha5);
      wr(MH, 8'h5a);
      rc(ML, 8'ha5);
      rc(MH, 8'h5a);
      wr(CTL, 8'h3c);
      rc(CTL, 8'h3c);
      wr(CCU_IDX_IRQ_ENABLES, 8'h04);
      cap(8'h04, 1, 16'h1234);
      cap(8'h05, 1, 16'hbeef);
      wr(TL, 8'h0f);
      pulse();
      rc(ML, 8'h0f);
      wr(CTL, 8'h06);
      pulse();
      pulse();
      // direct switch keeps the count of two, so 14 more rises reach the 16th
      wr(CTL, 8'h07);
      wr(FLG, 8'h00);
      repeat (13) pulse();
      rc(FLG, 8'h00);
      pulse();
      rc(FLG, 8'h04);
      cap(8'h06, 4, 16'h8001);
      cap(8'h07, 16, 16'h00ff);
      wr(CCU_IDX_PORT_DIR, 8'hf7);
      wr(CCU_IDX_PORT_OUT, 8'h00);
      wr(CTL, 8'h00);
      wr(FLG, 8'h00);
      wr(CTL, 8'h05);
      wr(CCU_IDX_PORT_OUT, 8'h08);
      repeat (6) @(posedge core_clk);
      rc(FLG, 8'h04);
      cmp(8'h08, 1);
      chk(pin_out, 1);
      cmp(8'h09, 0);
      chk(pin_out, 0);
      cmp(8'h08, 0);
      cmp(8'h0a, 0);
      chk(pin_out, 1);
      cmp(8'h0b, 1);
      chk(pin_out, 0);
      chk(se_cnt, 1);
      rc(TH, 8'h00);
      rd(TL);
      chk(rq < 32'h20, 1);
      wr(CCU_IDX_IRQ_ENABLES, 8'h00);
      chk(irq, 0);
      finish_test();
   end
endmodule
